// ### hdl/urx_top.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
module urx_top
  import urx_pkg::*;
#(
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_line,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rd_data
);
  // ==========================================
  // helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // data arrive lsb first into the top of the shifter
  function automatic logic [7:0] align(input logic [7:0] sh, input logic [1:0] len);
    logic [7:0] r;
    r = 8'h00;
    unique case (len)
      2'b00: r = {3'b000, sh[7:3]};
      2'b01: r = {2'b00, sh[7:2]};
      2'b10: r = {1'b0, sh[7:1]};
      2'b11: r = sh;
    endcase
    return r;
  endfunction : align

  // ==========================================
  // storage and baud tick
  urx_top_state_t s;
  urx_top_state_t next_s;
  logic tick;
  logic room;
  logic done;
  logic smp_half;
  logic smp_full;
  logic exp_par;
  logic [4:0] ovs_n;
  logic [2:0] last_bit;
  logic [7:0] act;
  logic rd_data_hit;
  logic [31:0] rd_word;

  urx_stream_if #(.WIDTH(10)) push_if ();
  urx_stream_if #(.WIDTH(10)) pop_if ();

  urx_fifo #(
    .WIDTH(10),
    .DEPTH(QUEUE_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .push(push_if.snk),
    .pop(pop_if.src)
  );

  urx_baud #(
    .WHOLE_W(16),
    .FRAC_W(6)
  ) u_baud (
    .clk_sys(clk_sys),
    .rst(rst),
    .whole(s.act_whole),
    .part(s.act_part),
    .tick(tick)
  );

  assign push_if.valid = s.push_valid;
  assign push_if.data = s.push_word;
  assign rd_data_hit = rd_strobe && hit(addr, `URX_OFS_DATA);
  assign pop_if.ready = rd_data_hit;
  assign rd_data = s.rd_data;
  assign act = s.act_line;

  // ==========================================
  // frame decode
  always_comb
  begin
    // sixteen or eight ticks per bit
    ovs_n = s.act_ovs ? `URX_OVS_FAST : `URX_OVS_SLOW;
    smp_full = tick && (s.smp == ovs_n - 5'h01);
    smp_half = tick && (s.smp == (ovs_n >> 1) - 5'h01);
    // last data bit index is four plus the length code
    last_bit = 3'h4 + {1'b0, act[`URX_LC_LEN_HI:`URX_LC_LEN_LO]};
    // par_acc holds the xor of the data bits seen so far
    if (act[`URX_LC_FIXED_PAR])
    begin
      exp_par = ~act[`URX_LC_EVEN_SEL];
    end
    else if (act[`URX_LC_EVEN_SEL])
    begin
      exp_par = s.par_acc;
    end
    else
    begin
      exp_par = ~s.par_acc;
    end
    // character mode lets one word wait, the queue lets the FIFO fill
    room = push_if.ready && (act[`URX_LC_QUEUE_ON] || !pop_if.valid);
  end

  // ==========================================
  // read mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit(addr, `URX_OFS_DATA))
    begin
      rd_word = pop_if.valid ? {22'h00_0000, pop_if.data} : 32'h0000_0000;
    end
    else if (hit(addr, `URX_OFS_STATUS))
    begin
      rd_word[`URX_FLAG_BUSY] = (s.phase != urx_idle);
      rd_word[`URX_FLAG_EMPTY] = !pop_if.valid;
      rd_word[`URX_FLAG_OVERRUN] = s.overrun;
      rd_word[`URX_FLAG_FULL] = !room;
    end
    else if (hit(addr, `URX_OFS_LINE))
    begin
      rd_word = {24'h00_0000, s.rx_line_control};
    end
    else if (hit(addr, `URX_OFS_WHOLE))
    begin
      rd_word = {16'h0000, s.baud_divisor_whole};
    end
    else if (hit(addr, `URX_OFS_PART))
    begin
      rd_word = {26'h000_0000, s.baud_divisor_part};
    end
    else if (hit(addr, `URX_OFS_CTRL))
    begin
      rd_word[`URX_CTRL_OVS] = s.oversample_sel;
    end
  end

  // ==========================================
  // next state
  always_comb
  begin
    next_s = s;
    done = 1'b0;
    next_s.sync1 = rx_line;
    next_s.sync2 = s.sync1;
    next_s.push_valid = 1'b0;
    next_s.rd_data = rd_strobe ? rd_word : 32'h0000_0000;

    // software side
    if (wr_strobe)
    begin
      if (hit(addr, `URX_OFS_LINE))
      begin
        next_s.rx_line_control = wr_data[7:0] & `URX_LC_MASK;
      end
      if (hit(addr, `URX_OFS_WHOLE))
      begin
        next_s.baud_divisor_whole = wr_data[15:0];
      end
      if (hit(addr, `URX_OFS_PART))
      begin
        next_s.baud_divisor_part = wr_data[5:0];
      end
      if (hit(addr, `URX_OFS_CTRL))
      begin
        next_s.oversample_sel = wr_data[`URX_CTRL_OVS];
      end
      if (hit(addr, `URX_OFS_STATUS) && wr_data[`URX_FLAG_OVERRUN])
      begin
        next_s.overrun = 1'b0;
      end
    end

    // receive machine
    unique case (s.phase)
      urx_idle:
      begin
        // settings only move across between characters
        next_s.act_whole = s.baud_divisor_whole;
        next_s.act_part = s.baud_divisor_part;
        next_s.act_ovs = s.oversample_sel;
        next_s.act_line = s.rx_line_control;
        next_s.smp = 5'h00;
        if (!s.sync2)
        begin
          next_s.phase = urx_start;
        end
      end
      urx_start:
      begin
        if (smp_half)
        begin
          next_s.smp = 5'h00;
          next_s.nbit = 3'h0;
          next_s.par_acc = 1'b0;
          next_s.ferr = 1'b0;
          next_s.perr = 1'b0;
          // a glitch shorter than half a bit is not a start
          next_s.phase = s.sync2 ? urx_idle : urx_data;
        end
        else if (tick)
        begin
          next_s.smp = s.smp + 5'h01;
        end
      end
      urx_data:
      begin
        if (smp_full)
        begin
          next_s.smp = 5'h00;
          next_s.shreg = {s.sync2, s.shreg[7:1]};
          next_s.par_acc = s.par_acc ^ s.sync2;
          next_s.nbit = s.nbit + 3'h1;
          if (s.nbit == last_bit)
          begin
            // no parity slot while parity is off
            next_s.phase = act[`URX_LC_PARITY_ON] ? urx_parity : urx_stop1;
          end
        end
        else if (tick)
        begin
          next_s.smp = s.smp + 5'h01;
        end
      end
      urx_parity:
      begin
        if (smp_full)
        begin
          next_s.smp = 5'h00;
          next_s.perr = (s.sync2 != exp_par);
          next_s.phase = urx_stop1;
        end
        else if (tick)
        begin
          next_s.smp = s.smp + 5'h01;
        end
      end
      urx_stop1:
      begin
        if (smp_full)
        begin
          next_s.smp = 5'h00;
          next_s.ferr = !s.sync2;
          if (act[`URX_LC_TWO_STOP])
          begin
            next_s.phase = urx_stop2;
          end
          else
          begin
            done = 1'b1;
            next_s.phase = urx_idle;
          end
        end
        else if (tick)
        begin
          next_s.smp = s.smp + 5'h01;
        end
      end
      urx_stop2:
      begin
        if (smp_full)
        begin
          next_s.smp = 5'h00;
          next_s.ferr = s.ferr || !s.sync2;
          done = 1'b1;
          next_s.phase = urx_idle;
        end
        else if (tick)
        begin
          next_s.smp = s.smp + 5'h01;
        end
      end
      default:
      begin
        next_s.phase = urx_idle;
      end
    endcase

    // hand the character over; the line cannot stall, so no room is an overrun
    if (done)
    begin
      next_s.push_word = {next_s.perr, next_s.ferr,
                          align(s.shreg, act[`URX_LC_LEN_HI:`URX_LC_LEN_LO])};
      if (room)
      begin
        next_s.push_valid = 1'b1;
      end
      else
      begin
        // set wins over a clear in the same cycle
        next_s.overrun = 1'b1;
      end
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.sync1 <= 1'b1;
      s.sync2 <= 1'b1;
      s.phase <= urx_idle;
      s.rx_line_control <= `URX_RST_LINE;
      s.baud_divisor_whole <= `URX_RST_WHOLE;
      s.baud_divisor_part <= `URX_RST_PART;
      s.oversample_sel <= `URX_RST_OVS;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : urx_top
`default_nettype wire

// ### hdl/urx_defs.svh
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
// ==========================================
// register byte offsets
`define URX_OFS_DATA 8'h00
`define URX_OFS_STATUS 8'h18
`define URX_OFS_LINE 8'h1c
`define URX_OFS_WHOLE 8'h24
`define URX_OFS_PART 8'h28
`define URX_OFS_CTRL 8'h30
// ==========================================
// line control fields
`define URX_LC_PARITY_ON 1
`define URX_LC_EVEN_SEL 2
`define URX_LC_TWO_STOP 3
`define URX_LC_QUEUE_ON 4
`define URX_LC_LEN_LO 5
`define URX_LC_LEN_HI 6
`define URX_LC_FIXED_PAR 7
`define URX_LC_MASK 8'hfe
// ==========================================
// control, status and data fields
`define URX_CTRL_OVS 3
`define URX_FLAG_BUSY 3
`define URX_FLAG_EMPTY 4
`define URX_FLAG_OVERRUN 5
`define URX_FLAG_FULL 6
`define URX_DAT_FERR 8
`define URX_DAT_PERR 9
// ==========================================
// reset values
`define URX_RST_LINE 8'h00
`define URX_RST_WHOLE 16'h0000
`define URX_RST_PART 6'h00
`define URX_RST_OVS 1'h0
// ==========================================
// oversampling ticks per bit
`define URX_OVS_SLOW 5'h10
`define URX_OVS_FAST 5'h08
`endif

// ### hdl/urx_pkg.sv
`default_nettype none
package urx_pkg;
  // ==========================================
  // receiver states
  typedef enum logic [2:0]
  {
    urx_idle,
    urx_start,
    urx_data,
    urx_parity,
    urx_stop1,
    urx_stop2
  } urx_rx_state_t;

  // ==========================================
  // top-level state
  typedef struct packed {
    logic sync1;
    logic sync2;
    urx_rx_state_t phase;
    logic [4:0] smp;
    logic [2:0] nbit;
    logic [7:0] shreg;
    logic par_acc;
    logic ferr;
    logic perr;
    logic [7:0] rx_line_control;
    logic [15:0] baud_divisor_whole;
    logic [5:0] baud_divisor_part;
    logic oversample_sel;
    logic [7:0] act_line;
    logic [15:0] act_whole;
    logic [5:0] act_part;
    logic act_ovs;
    logic overrun;
    logic push_valid;
    logic [9:0] push_word;
    logic [31:0] rd_data;
  } urx_top_state_t;
endpackage : urx_pkg
`default_nettype wire

// ### hdl/urx_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface urx_stream_if #(
  parameter int WIDTH = 10
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : urx_stream_if
`default_nettype wire

// ### hdl/urx_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module urx_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  urx_stream_if.snk push,
  urx_stream_if.src pop
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } urx_fifo_state_t;

  urx_fifo_state_t s;
  urx_fifo_state_t next_s;
  logic do_push;
  logic do_pop;

  assign push.ready = (s.cnt != FULL_CNT);
  assign pop.valid = (s.cnt != '0);
  assign pop.data = s.mem[s.rp];
  assign do_push = push.valid && push.ready;
  assign do_pop = pop.valid && pop.ready;

  always_comb
  begin
    next_s = s;
    if (do_push)
    begin
      next_s.mem[s.wp] = push.data;
      next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
    end
    if (do_pop)
    begin
      next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : urx_fifo
`default_nettype wire

// ### hdl/urx_baud.sv
`timescale 1ns/1ps
`default_nettype none
module urx_baud #(
  parameter int WHOLE_W = 16,
  parameter int FRAC_W = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WHOLE_W-1:0] whole,
  input wire logic [FRAC_W-1:0] part,
  output logic tick
);
  typedef struct packed {
    logic [WHOLE_W:0] cnt;
    logic [FRAC_W-1:0] acc;
    logic tick;
  } urx_baud_state_t;

  urx_baud_state_t s;
  urx_baud_state_t next_s;
  logic [FRAC_W:0] sum;
  logic [WHOLE_W:0] period;

  assign tick = s.tick;

  // fraction in 1/64 units: a carry stretches this period by one clock
  always_comb
  begin
    sum = {1'b0, s.acc} + {1'b0, part};
    period = {1'b0, whole} + {{WHOLE_W{1'b0}}, sum[FRAC_W]};
    next_s = s;
    next_s.tick = 1'b0;
    if (whole == '0)
    begin
      // zero divisor holds the receiver still
      next_s.cnt = '0;
      next_s.acc = '0;
    end
    else if (s.cnt >= period - 1'b1)
    begin
      next_s.tick = 1'b1;
      next_s.cnt = '0;
      next_s.acc = sum[FRAC_W-1:0];
    end
    else
    begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : urx_baud
`default_nettype wire

// ### verification/urx_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "urx_defs.svh"
// ==========================================
// register port checker
module urx_props #(
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic rx_line,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [31:0] rd_data
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // the bench leaves one idle cycle between a write and the read back
  sequence wr_rd(logic [7:0] a);
    wr_strobe && addr == a ##2 rd_strobe && addr == a;
  endsequence
  a_read_idle_zero: assert property (!$past(rd_strobe) |-> rd_data == 32'h0)
    else $error("read data not zero outside a read");
  a_line_back: assert property (wr_rd(`URX_OFS_LINE) |=>
    rd_data == {24'h0, $past(wr_data[7:1], 3), 1'b0})
    else $error("line control read back wrong");
  a_whole_back: assert property (wr_rd(`URX_OFS_WHOLE) |=>
    rd_data == {16'h0, $past(wr_data[15:0], 3)})
    else $error("whole divisor read back wrong");
  a_part_back: assert property (wr_rd(`URX_OFS_PART) |=>
    rd_data == {26'h0, $past(wr_data[5:0], 3)})
    else $error("fractional divisor read back wrong");
  a_ovs_back: assert property (wr_rd(`URX_OFS_CTRL) |=>
    rd_data == {28'h0, $past(wr_data[3], 3), 3'h0})
    else $error("oversample select read back wrong");
  a_status_spare: assert property (rd_strobe && addr == `URX_OFS_STATUS |=>
    rd_data[31:7] == 25'h0 && rd_data[2:0] == 3'h0)
    else $error("status spare bits set");
  a_data_spare: assert property (rd_strobe && addr == `URX_OFS_DATA |=>
    rd_data[31:10] == 22'h0)
    else $error("data word spare bits set");
  a_unmapped_zero: assert property (rd_strobe && addr == 8'h04 |=> rd_data == 32'h0)
    else $error("unmapped read not zero");
  a_empty_full_excl: assert property (rd_strobe && addr == `URX_OFS_STATUS |=>
    !(rd_data[4] && rd_data[6]))
    else $error("status shows empty and full together");
  c_start_edge: cover property (rx_line ##1 !rx_line);
  c_parity_err: cover property (rd_strobe && addr == `URX_OFS_DATA ##1 rd_data[9]);
  c_frame_err: cover property (rd_strobe && addr == `URX_OFS_DATA ##1 rd_data[8]);
  c_queue_full: cover property (rd_strobe && addr == `URX_OFS_STATUS ##1 rd_data[6]);
endmodule : urx_props
bind urx_top urx_props #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_urx_props (.clk_sys(clk_sys), .rst(rst),
  .rx_line(rx_line), .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rd_data(rd_data));
`default_nettype wire

// ### verification/urx_remote_tx.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// remote serial transmitter
module urx_remote_tx (
  input wire logic clk_sys,
  output logic rx_line
);
  initial rx_line = 1'b1;
  // par below zero means no parity bit; ns stop bits taken from stp, lsb first
  task automatic send(input logic [7:0] d, input int nb, input int par,
    input logic [1:0] stp, input int ns, input int bc);
    logic [11:0] f;
    int n;
    f = 12'hfff;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++)
      f[1 + i] = d[i];
    n = nb + 1;
    if (par >= 0)
    begin
      f[n] = par[0];
      n++;
    end
    f[n] = stp[0];
    f[n + 1] = stp[1];
    n = n + ns;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      rx_line <= f[i];
      repeat (bc - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask : send
endmodule : urx_remote_tx
`default_nettype wire

// ### verification/tb_urx_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// testbench
module tb_urx_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  wire logic rx_line;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] s;
  int error_cnt = 0;
  int tests_run = 0;
  int bc = 32;
  always #5 clk_sys = ~clk_sys;
  urx_top #(.QUEUE_DEPTH(4)) u_urx_top (.clk_sys(clk_sys), .rst(rst), .rx_line(rx_line),
    .addr(addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rd_data(rd_data));
  urx_remote_tx u_urx_remote_tx (.clk_sys(clk_sys), .rx_line(rx_line));
  // ==========================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    tests_run++;
    if (d !== e)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, d, e);
    end
  endtask : chk
  task automatic cfg(input logic [7:0] lc, input logic [15:0] w, input logic [5:0] p,
    input logic o);
    wr(8'h1c, {24'h0, lc});
    wr(8'h24, {16'h0, w});
    wr(8'h28, {26'h0, p});
    wr(8'h30, {28'h0, o, 3'h0});
    bc = ((o ? 8 : 16) * (int'(w) * 64 + int'(p))) / 64;
  endtask : cfg
  // polling is bounded so a lost character cannot hang the run
  task automatic wait_char;
    s = 32'h10;
    for (int i = 0; i < 100 && s[4] !== 1'b0; i++)
      rd(8'h18, s);
  endtask : wait_char
  task automatic go(input logic [7:0] lc, input logic [7:0] d, input int nb, input int par,
    input logic [1:0] stp, input int ns, input logic [31:0] e);
    wr(8'h1c, {24'h0, lc});
    u_urx_remote_tx.send(d, nb, par, stp, ns, bc);
    wait_char();
    chk(8'h00, e);
  endtask : go
  task automatic report_and_stop;
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // ==========================================
  // sequence
  initial
  begin
    // about five times the expected run length
    #500000;
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    chk(8'h1c, 32'h0);
    chk(8'h24, 32'h0);
    chk(8'h28, 32'h0);
    chk(8'h30, 32'h0);
    chk(8'h18, 32'h10);
    chk(8'h04, 32'h0);
    wr(8'h1c, '1);
    chk(8'h1c, 32'hfe);
    wr(8'h24, '1);
    chk(8'h24, 32'hffff);
    wr(8'h28, '1);
    chk(8'h28, 32'h3f);
    wr(8'h30, '1);
    chk(8'h30, 32'h8);
    cfg(8'h60, 16'h2, 6'h0, 1'b0);
    go(8'h60, 8'ha5, 8, -1, 2'b11, 1, 32'h0a5);
    go(8'h00, 8'hff, 5, -1, 2'b11, 1, 32'h01f);
    go(8'h20, 8'hff, 6, -1, 2'b11, 1, 32'h03f);
    go(8'h40, 8'hff, 7, -1, 2'b11, 1, 32'h07f);
    go(8'h62, 8'h03, 8, 1, 2'b11, 1, 32'h003);
    go(8'h62, 8'h03, 8, 0, 2'b11, 1, 32'h203);
    go(8'h66, 8'h03, 8, 0, 2'b11, 1, 32'h003);
    go(8'h66, 8'h03, 8, 1, 2'b11, 1, 32'h203);
    go(8'he2, 8'h07, 8, 1, 2'b11, 1, 32'h007);
    go(8'he2, 8'h07, 8, 0, 2'b11, 1, 32'h207);
    go(8'he6, 8'h07, 8, 0, 2'b11, 1, 32'h007);
    go(8'h68, 8'h5a, 8, -1, 2'b11, 2, 32'h05a);
    go(8'h68, 8'h5a, 8, -1, 2'b01, 2, 32'h15a);
    // the low second stop bit may pass for a new start; let that frame end and drop it
    repeat (12 * bc) @(posedge clk_sys);
    rd(8'h00, s);
    cfg(8'h60, 16'h2, 6'h0, 1'b0);
    u_urx_remote_tx.send(8'ha1, 8, -1, 2'b11, 1, bc);
    u_urx_remote_tx.send(8'ha2, 8, -1, 2'b11, 1, bc);
    chk(8'h18, 32'h60);
    chk(8'h00, 32'h0a1);
    chk(8'h18, 32'h30);
    wr(8'h18, 32'h20);
    wr(8'h1c, 32'h70);
    for (int i = 0; i < 5; i++)
      u_urx_remote_tx.send(8'h10 + 8'(i), 8, -1, 2'b11, 1, bc);
    chk(8'h18, 32'h60);
    for (int i = 0; i < 4; i++)
      chk(8'h00, 32'h10 + i);
    chk(8'h18, 32'h30);
    wr(8'h18, 32'h20);
    cfg(8'h60, 16'h1, 6'h0, 1'b1);
    go(8'h60, 8'h96, 8, -1, 2'b11, 1, 32'h096);
    cfg(8'h60, 16'h2, 6'h20, 1'b0);
    go(8'h60, 8'hc3, 8, -1, 2'b11, 1, 32'h0c3);
    cfg(8'h60, 16'h3, 6'h0, 1'b1);
    go(8'h60, 8'h3c, 8, -1, 2'b11, 1, 32'h03c);
    cfg(8'h60, 16'h2, 6'h0, 1'b0);
    fork
      u_urx_remote_tx.send(8'h69, 8, -1, 2'b11, 1, bc);
      begin
        repeat (100) @(posedge clk_sys);
        wr(8'h24, 32'h4);
      end
    join
    wait_char();
    chk(8'h00, 32'h069);
    bc = 64;
    go(8'h60, 8'h81, 8, -1, 2'b11, 1, 32'h081);
    report_and_stop();
  end
endmodule : tb_urx_top
`default_nettype wire
